// ---- fbost_tracker.sv ----
// command front end and per-bank output state tracker
`timescale 1ns/100ps
`default_nettype none
module fbost_tracker #(
	parameter int NUM_BANKS = fbost_pkg::NUM_BANKS
) (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic WR_STB,
	input wire fbost_pkg::fbost_write_type WR_IN,
	input wire logic [fbost_pkg::BANK_W-1:0] RD_BANK,
	input wire logic PEC_DONE,
	output fbost_pkg::fbost_out_type RD_SEL,
	output logic RD_MATCH,
	output fbost_pkg::fbost_state_type FE_STATE,
	output logic PEC_START,
	output logic CMD_ILLEGAL,
	output logic CMD_IGNORED
);
	import fbost_pkg::*;

	fbost_state_type state_ff, nxt_state;
	logic [BANK_W-1:0] cmd_bank_ff;
	logic [BLOCK_W-1:0] first_block_ff;
	logic susp_ff;
	logic out_wr;
	fbost_out_type out_val;
	logic [1:0] mem_rd;
	logic start_ff, ill_ff, ign_ff, match_ff;
	fbost_out_type sel_ff;
	// second cycle of a dropped setup pair is swallowed as well
	logic drop_ff;
	logic [7:0] code;
	logic busy;

	initial begin
		if (NUM_BANKS < 1 || NUM_BANKS > (1 << BANK_W)) begin
			$error("fbost_tracker: bank count out of range");
		end
	end

	function automatic logic known_code(input logic [7:0] c);
		case (c)
			CMD_READ_ARRAY, CMD_READ_STATUS, CMD_READ_SIG, CMD_READ_QUERY, CMD_CLEAR_STATUS,
			CMD_PROG_SETUP, CMD_PROG_ALT, CMD_ERASE_SETUP, CMD_BUF_PROG, CMD_BULK_SETUP,
			CMD_CONFIRM, CMD_SUSPEND, CMD_LOCK_SETUP, CMD_OTP_SETUP, CMD_BLANK_SETUP,
			CMD_BLANK_CONFIRM, CMD_LOCK_CONFIRM, CMD_LOCKDOWN_CONFIRM, CMD_SET_CFG_CONFIRM: known_code = 1'b1;
			default: known_code = 1'b0;
		endcase
	endfunction

	function automatic logic is_busy(input fbost_state_type s);
		is_busy = (s == FBOST_PROG_BUSY) || (s == FBOST_ERASE_BUSY) || (s == FBOST_BUF_BUSY) ||
			(s == FBOST_OTP_BUSY) || (s == FBOST_BLANK_BUSY) || (s == FBOST_BULK_BUSY);
	endfunction

	assign code = WR_IN.data[7:0];
	assign busy = is_busy(state_ff);

	// next front end state: depends on state, suspend and drop flags, the written word and block, and completion, never on bank outputs
	always_comb begin
		nxt_state = state_ff;
		if (WR_STB && !drop_ff) begin
			case (state_ff)
				FBOST_READY, FBOST_SUSPEND, FBOST_ILLEGAL: begin
					case (code)
						CMD_PROG_SETUP, CMD_PROG_ALT: nxt_state = FBOST_PROG_SETUP;
						CMD_ERASE_SETUP: nxt_state = susp_ff ? state_ff : FBOST_ERASE_SETUP;
						CMD_BUF_PROG: nxt_state = FBOST_BUF_SETUP;
						CMD_BULK_SETUP: nxt_state = susp_ff ? state_ff : FBOST_BULK_SETUP;
						CMD_LOCK_SETUP: nxt_state = FBOST_LOCK_SETUP;
						CMD_OTP_SETUP: nxt_state = susp_ff ? state_ff : FBOST_OTP_SETUP;
						CMD_BLANK_SETUP: nxt_state = susp_ff ? state_ff : FBOST_BLANK_SETUP;
						CMD_CONFIRM: nxt_state = susp_ff ? FBOST_ERASE_BUSY : state_ff;
						default: nxt_state = known_code(code) ? state_ff : FBOST_ILLEGAL;
					endcase
				end
				FBOST_PROG_SETUP: nxt_state = FBOST_PROG_BUSY;
				FBOST_OTP_SETUP: nxt_state = FBOST_OTP_BUSY;
				FBOST_ERASE_SETUP: nxt_state = (code == CMD_CONFIRM) ? FBOST_ERASE_BUSY : FBOST_ILLEGAL;
				FBOST_BUF_SETUP: nxt_state = (code == CMD_CONFIRM) ? FBOST_BUF_BUSY : FBOST_BUF_SETUP;
				FBOST_BLANK_SETUP: nxt_state = (code == CMD_BLANK_CONFIRM) ? FBOST_BLANK_BUSY : FBOST_ILLEGAL;
				FBOST_BULK_SETUP: nxt_state = (code == CMD_CONFIRM) ? FBOST_BULK_BUSY : FBOST_ILLEGAL;
				FBOST_LOCK_SETUP: begin
					case (code)
						CMD_LOCK_CONFIRM, CMD_LOCKDOWN_CONFIRM, CMD_CONFIRM, CMD_SET_CFG_CONFIRM:
							nxt_state = susp_ff ? FBOST_SUSPEND : FBOST_READY;
						default: nxt_state = FBOST_ILLEGAL;
					endcase
				end
				FBOST_BULK_BUSY: begin
					// leaving bulk mode needs all-ones data outside the first block
					if (WR_IN.data == BULK_EXIT_DATA && WR_IN.block != first_block_ff) begin
						nxt_state = FBOST_READY;
					end
				end
				FBOST_PROG_BUSY, FBOST_ERASE_BUSY, FBOST_BUF_BUSY: begin
					if (code == CMD_SUSPEND && !susp_ff && state_ff == FBOST_ERASE_BUSY) begin
						nxt_state = FBOST_SUSPEND;
					end
				end
				default: nxt_state = state_ff;
			endcase
		end
		// completion wins over a write landing in the same cycle
		if (busy && PEC_DONE && state_ff != FBOST_BULK_BUSY) begin
			nxt_state = (susp_ff && state_ff != FBOST_ERASE_BUSY) ? FBOST_SUSPEND : FBOST_READY;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			state_ff <= FBOST_READY;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// suspend flag: erase is parked while a program may run
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			susp_ff <= 1'b0;
		end else if (state_ff == FBOST_ERASE_BUSY && nxt_state == FBOST_SUSPEND) begin
			susp_ff <= 1'b1;
		end else if (state_ff == FBOST_SUSPEND && nxt_state == FBOST_ERASE_BUSY) begin
			susp_ff <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			drop_ff <= 1'b0;
		end else if (WR_STB) begin
			drop_ff <= !drop_ff && busy && (code == CMD_LOCK_SETUP || code == CMD_OTP_SETUP);
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			cmd_bank_ff <= '0;
			first_block_ff <= '0;
		end else if (WR_STB) begin
			cmd_bank_ff <= WR_IN.bank;
			if (state_ff == FBOST_BULK_SETUP) begin
				first_block_ff <= WR_IN.block;
			end
		end
	end

	// output selection written only into the addressed bank
	always_comb begin
		out_wr = 1'b0;
		out_val = FBOST_OUT_STATUS;
		if (WR_STB && !drop_ff && !(busy && (code == CMD_LOCK_SETUP || code == CMD_OTP_SETUP))) begin
			case (code)
				CMD_READ_ARRAY: begin
					out_wr = !busy;
					out_val = FBOST_OUT_ARRAY;
				end
				CMD_READ_SIG: begin
					out_wr = 1'b1;
					out_val = FBOST_OUT_SIG;
				end
				CMD_READ_QUERY: begin
					out_wr = 1'b1;
					out_val = FBOST_OUT_QUERY;
				end
				CMD_SET_CFG_CONFIRM: begin
					out_wr = (state_ff == FBOST_LOCK_SETUP);
					out_val = FBOST_OUT_ARRAY;
				end
				CMD_LOCK_CONFIRM, CMD_LOCKDOWN_CONFIRM: out_wr = 1'b0;
				default: out_wr = 1'b1;
			endcase
		end
	end

	fbost_bank_mem #(
		.DEPTH(NUM_BANKS),
		.AW(BANK_W)
	) u_mem (
		.CLK_SYS(CLK_SYS),
		.RST_N(RST_N),
		.wr_en(out_wr),
		.wr_addr(WR_IN.bank),
		.wr_data(out_val),
		.rd_addr(RD_BANK),
		.rd_data_ff(mem_rd)
	);

	// read selection holds only when read bank is the command bank
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			match_ff <= 1'b0;
		end else begin
			match_ff <= (RD_BANK == cmd_bank_ff);
		end
	end

	// output flop costs a cycle of read latency but keeps the pin glitch free
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			sel_ff <= FBOST_OUT_ARRAY;
		end else begin
			sel_ff <= match_ff ? fbost_out_type'(mem_rd) : FBOST_OUT_ARRAY;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			start_ff <= 1'b0;
			ill_ff <= 1'b0;
			ign_ff <= 1'b0;
		end else begin
			start_ff <= is_busy(nxt_state) && !busy;
			ill_ff <= WR_STB && nxt_state == FBOST_ILLEGAL && state_ff != FBOST_ILLEGAL;
			ign_ff <= WR_STB && !drop_ff && busy && (code == CMD_LOCK_SETUP || code == CMD_OTP_SETUP);
		end
	end

	assign RD_SEL = sel_ff;
	assign RD_MATCH = match_ff;
	assign FE_STATE = state_ff;
	assign PEC_START = start_ff;
	assign CMD_ILLEGAL = ill_ff;
	assign CMD_IGNORED = ign_ff;
endmodule
`default_nettype wire

// ---- fbost_pkg.sv ----
// package: command codes, states and carriers for the bank output state tracker
package fbost_pkg;
	localparam int NUM_BANKS = 16;
	localparam int BANK_W = 4;
	localparam int BLOCK_W = 7;
	// command codes (low byte of the written word)
	localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_READ_SIG = 8'h90;
	localparam logic [7:0] CMD_READ_QUERY = 8'h98;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
	localparam logic [7:0] CMD_PROG_ALT = 8'h10;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] CMD_BUF_PROG = 8'he8;
	localparam logic [7:0] CMD_BULK_SETUP = 8'h80;
	localparam logic [7:0] CMD_CONFIRM = 8'hd0;
	localparam logic [7:0] CMD_SUSPEND = 8'hb0;
	localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
	localparam logic [7:0] CMD_OTP_SETUP = 8'hc0;
	localparam logic [7:0] CMD_BLANK_SETUP = 8'hbc;
	localparam logic [7:0] CMD_BLANK_CONFIRM = 8'hcb;
	localparam logic [7:0] CMD_LOCK_CONFIRM = 8'h01;
	localparam logic [7:0] CMD_LOCKDOWN_CONFIRM = 8'h2f;
	localparam logic [7:0] CMD_SET_CFG_CONFIRM = 8'h03;
	localparam logic [15:0] BULK_EXIT_DATA = 16'hffff;
	// per-bank output selection
	typedef enum logic [1:0] {
		FBOST_OUT_ARRAY = 2'h0,
		FBOST_OUT_STATUS = 2'h1,
		FBOST_OUT_SIG = 2'h3,
		FBOST_OUT_QUERY = 2'h2
	} fbost_out_type;
	// command front end states
	typedef enum logic [3:0] {
		FBOST_READY = 4'h0,
		FBOST_PROG_SETUP = 4'h1,
		FBOST_PROG_BUSY = 4'h3,
		FBOST_ERASE_SETUP = 4'h2,
		FBOST_ERASE_BUSY = 4'h6,
		FBOST_BUF_SETUP = 4'h7,
		FBOST_BUF_BUSY = 4'h5,
		FBOST_SUSPEND = 4'h4,
		FBOST_LOCK_SETUP = 4'hc,
		FBOST_OTP_SETUP = 4'hd,
		FBOST_OTP_BUSY = 4'hf,
		FBOST_BLANK_SETUP = 4'he,
		FBOST_BLANK_BUSY = 4'ha,
		FBOST_BULK_SETUP = 4'hb,
		FBOST_BULK_BUSY = 4'h9,
		FBOST_ILLEGAL = 4'h8
	} fbost_state_type;
	// one bus write as seen by the front end
	typedef struct packed {
		logic [BANK_W-1:0] bank;
		logic [BLOCK_W-1:0] block;
		logic [15:0] data;
	} fbost_write_type;
endpackage

// ---- fbost_bank_mem.sv ----
// memory of per-bank output states with registered read port
`timescale 1ns/100ps
`default_nettype none
module fbost_bank_mem #(
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [1:0] rd_data_ff
);
	logic [1:0] mem_ff [DEPTH];

	initial begin
		if (DEPTH > (1 << AW) || DEPTH < 1) begin
			$error("fbost_bank_mem: depth does not fit address width");
		end
	end

	always_ff @(posedge CLK_SYS) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (!RST_N) begin
				mem_ff[i] <= 2'h0;
			end else if (wr_en && wr_addr == AW'(i)) begin
				mem_ff[i] <= wr_data;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			rd_data_ff <= 2'h0;
		end else begin
			rd_data_ff <= mem_ff[rd_addr];
		end
	end
endmodule
`default_nettype wire

// ---- fbost_tracker_asserts.sv ----
// checker: concurrent assertions on the tracker ports
`timescale 1ns/100ps
`default_nettype none
module fbost_tracker_asserts
	import fbost_pkg::*;
#(
	parameter int NUM_BANKS = 16
) (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic WR_STB,
	input wire fbost_pkg::fbost_write_type WR_IN,
	input wire logic [3:0] RD_BANK,
	input wire logic PEC_DONE,
	input wire fbost_pkg::fbost_out_type RD_SEL,
	input wire logic RD_MATCH,
	input wire fbost_pkg::fbost_state_type FE_STATE,
	input wire logic PEC_START,
	input wire logic CMD_ILLEGAL,
	input wire logic CMD_IGNORED
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	// bulk mode is left out: only the exit write ends it
	wire logic busy = FE_STATE inside {FBOST_PROG_BUSY, FBOST_ERASE_BUSY, FBOST_BUF_BUSY, FBOST_OTP_BUSY,
		FBOST_BLANK_BUSY};
	wire logic [7:0] code = WR_IN.data[7:0];
	sequence s_erase_pair;
		FE_STATE == FBOST_READY && WR_STB && code == CMD_ERASE_SETUP ##1 WR_STB && code == CMD_CONFIRM;
	endsequence
	chk_erase_walk: assert property (s_erase_pair |=> FE_STATE == FBOST_ERASE_BUSY && PEC_START)
		else $error("erase pair did not start the controller");
	chk_ign_cause: assert property (CMD_IGNORED |-> $past(WR_STB) && $past(code) inside {8'h60, 8'hc0})
		else $error("ignore pulse without a setup write");
	chk_ign_busy: assert property (CMD_IGNORED |-> $past(busy) || $past(FE_STATE) == FBOST_BULK_BUSY)
		else $error("ignore pulse while idle");
	chk_start_busy: assert property (PEC_START |-> busy || FE_STATE == FBOST_BULK_BUSY)
		else $error("start pulse outside a busy state");
	chk_busy_hold: assert property (busy && !PEC_DONE && !WR_STB |=> $stable(FE_STATE))
		else $error("busy state left without completion");
	chk_done_release: assert property (busy && PEC_DONE |=> FE_STATE inside {FBOST_READY, FBOST_SUSPEND})
		else $error("completion did not release busy");
	chk_illegal_state: assert property (CMD_ILLEGAL |-> FE_STATE == FBOST_ILLEGAL)
		else $error("illegal pulse without illegal state");
	chk_match_array: assert property (!RD_MATCH |=> RD_SEL == FBOST_OUT_ARRAY)
		else $error("foreign bank read not showing array");
endmodule
bind fbost_tracker fbost_tracker_asserts #(.NUM_BANKS(NUM_BANKS)) u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
	.WR_STB(WR_STB), .WR_IN(WR_IN), .RD_BANK(RD_BANK), .PEC_DONE(PEC_DONE), .RD_SEL(RD_SEL),
	.RD_MATCH(RD_MATCH), .FE_STATE(FE_STATE), .PEC_START(PEC_START), .CMD_ILLEGAL(CMD_ILLEGAL),
	.CMD_IGNORED(CMD_IGNORED));
`default_nettype wire

// ---- fbost_pec_model.sv ----
// partner model: program/erase controller answering a start with a done pulse
`timescale 1ns/100ps
`default_nettype none
module fbost_pec_model (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [7:0] delay,
	output logic done
);
	int cnt_ff;
	// a new start restarts the count, one operation at a time
	always @(posedge clk_sys) begin
		done <= 1'b0;
		if (!rst_n) begin
			cnt_ff <= 0;
		end else if (start) begin
			cnt_ff <= delay;
		end else if (cnt_ff > 0) begin
			cnt_ff <= cnt_ff - 1;
			done <= (cnt_ff == 1);
		end
	end
endmodule
`default_nettype wire

// ---- flash_bank_output_state_tracker_test.sv ----
// testbench: tracker against a per-bank model
`timescale 1ns/100ps
`default_nettype none
module flash_bank_output_state_tracker_test;
	import fbost_pkg::*;
	logic clk_sys = 0;
	logic rst_n = 0;
	logic wr_stb = 0;
	fbost_write_type wr_in = '0;
	logic [3:0] rd_bank = '0;
	logic [7:0] pec_delay = 8'h08;
	logic pec_start, pec_done, rd_match, cmd_illegal, cmd_ignored;
	fbost_out_type rd_sel;
	fbost_state_type fe_state;
	int err_total = 0;
	int n_compared = 0;
	int cycles = 0;
	int sel_q[16];
	int last_bank = 0;
	logic [7:0] rcmd[4] = '{CMD_READ_ARRAY, CMD_READ_STATUS, CMD_READ_QUERY, CMD_READ_SIG};
	fbost_tracker u_dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .WR_STB(wr_stb), .WR_IN(wr_in), .RD_BANK(rd_bank),
		.PEC_DONE(pec_done), .RD_SEL(rd_sel), .RD_MATCH(rd_match), .FE_STATE(fe_state), .PEC_START(pec_start),
		.CMD_ILLEGAL(cmd_illegal), .CMD_IGNORED(cmd_ignored));
	fbost_pec_model u_pec (.clk_sys(clk_sys), .rst_n(rst_n), .start(pec_start), .delay(pec_delay),
		.done(pec_done));
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// more keeps the strobe up so the next call lands in the following cycle
	task automatic wr(logic [3:0] b, logic [6:0] blk, logic [15:0] d, bit more = 0);
		if (!wr_stb) begin
			@(posedge clk_sys);
			#10;
		end
		wr_stb = 1;
		wr_in = '{bank: b, block: blk, data: d};
		@(posedge clk_sys);
		#10;
		if (!more) wr_stb = 0;
		last_bank = b;
	endtask
	task automatic rd(logic [3:0] b);
		@(posedge clk_sys);
		#10;
		rd_bank = b;
		repeat (2) @(posedge clk_sys);
		#10;
		chk("rd_sel", rd_sel, (b == last_bank) ? sel_q[b] : 0);
	endtask
	task automatic do_reset();
		@(posedge clk_sys);
		#10;
		rst_n = 0;
		repeat (20) @(posedge clk_sys);
		#10;
		rst_n = 1;
		foreach (sel_q[i]) sel_q[i] = 0;
		last_bank = 0;
	endtask
	task automatic close_out();
		if (err_total == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			close_out();
		end
	end
	initial begin
		int r;
		void'($urandom(69));
		r = $urandom_range(3);
		do_reset();
		for (int i = 0; i < 16; i++) begin
			wr(i[3:0], 7'h00, {8'h00, rcmd[(i + r) % 4]});
			sel_q[i] = (i + r) % 4;
			rd(($urandom_range(1)) ? i[3:0] : 4'($urandom_range(15)));
		end
		// erase on a bank whose output is not array: next state must not care
		wr(4'h2, 7'h01, 16'h0020, 1);
		sel_q[2] = 1;
		chk("fe_state", fe_state, FBOST_ERASE_SETUP);
		wr(4'h2, 7'h01, 16'h00d0);
		chk("fe_state", fe_state, FBOST_ERASE_BUSY);
		for (int k = 0; k < 2; k++) begin
			wr(4'h2, 7'h01, k[0] ? 16'h00c0 : 16'h0060);
			chk("cmd_ignored", cmd_ignored, 1);
			wr(4'h2, 7'h01, 16'h0098);
			chk("cmd_ignored", cmd_ignored, 0);
			chk("fe_state", fe_state, FBOST_ERASE_BUSY);
		end
		repeat (40) begin
			@(posedge clk_sys);
			#10;
			if (fe_state === FBOST_READY) break;
		end
		chk("fe_state", fe_state, FBOST_READY);
		rd(4'h2);
		pec_delay = 8'($urandom_range(12, 3));
		wr(4'h1, 7'h05, 16'h0080);
		wr(4'h1, 7'h05, 16'h00d0);
		wr(4'h1, 7'h05, 16'($urandom));
		wr(4'h1, 7'h05, 16'hffff);
		chk("bulk_stay", fe_state, FBOST_BULK_BUSY);
		wr(4'h1, 7'h06, 16'hffff);
		chk("bulk_exit", fe_state, FBOST_READY);
		do_reset();
		wr(4'h0, 7'h00, 16'h0060);
		chk("fe_state", fe_state, FBOST_LOCK_SETUP);
		do_reset();
		wr(4'h0, 7'h00, 16'h0033);
		chk("cmd_illegal", cmd_illegal, 1);
		close_out();
	end
endmodule
`default_nettype wire
